// File: fmbs_pkg.sv
package fmbs_pkg;

  // Bus widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // Command codes on the first and second write cycles
  localparam logic [7:0] CMD_READ_ARRAY    = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS   = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS  = 8'h50;
  localparam logic [7:0] CMD_PROGRAM       = 8'h40;
  localparam logic [7:0] CMD_ERASE         = 8'h20;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
  localparam int         NUM_COMMANDS      = 6;

  // Area layout; boot area is one erase block of its own
  localparam int             BOOT_AREA_BYTES = 4096;
  localparam logic [15:0]    USER_BASE       = 16'h8000;
  localparam logic [15:0]    BOOT_TOP        = 16'hFFFF;
  localparam logic [15:0]    BOOT_BASE       =
    16'(32'(BOOT_TOP) + 32'h1 - 32'(BOOT_AREA_BYTES));
  localparam int             USER_BLOCKS     = 4;
  localparam int             BLK_W           = 2;
  localparam logic [15:0]    USER_BLOCK_TOP [USER_BLOCKS] =
    '{16'h9FFF, 16'hBFFF, 16'hDFFF, 16'hFFFF};

  // Status byte layout and reset value
  localparam int          SR_READY_BIT     = 7;
  localparam int          SR_ERASE_ERR_BIT = 5;
  localparam int          SR_PROG_ERR_BIT  = 4;
  localparam logic [7:0]  STATUS_RESET     = 8'h80;
  localparam logic [7:0]  DATA_ZERO        = 8'h00;

  // Party driving the command port
  typedef enum logic [1:0] {
    SRC_CPU,
    SRC_PARALLEL,
    SRC_SERIAL
  } fmbs_src_t;

  // Start area chosen at reset release
  typedef enum logic [1:0] {
    START_USER,
    START_BOOT,
    START_PROGRAMMER
  } fmbs_start_t;

  // Array operations
  typedef enum logic [1:0] {
    OP_PROGRAM,
    OP_ERASE_BLOCK,
    OP_ERASE_ALL
  } fmbs_op_t;

endpackage

// File: fmbs_area_decode.sv
module fmbs_area_decode
  import fmbs_pkg::*;
(
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              boot_sel,
  output logic                   in_user,
  output logic                   in_boot,
  output logic                   user_top_hit,
  output logic                   boot_top_hit,
  output logic [BLK_W-1:0]       blk_idx
);

  logic [USER_BLOCKS-1:0] hit;

  // One top-address comparator per user block
  genvar g;
  generate
    for (g = 0; g < USER_BLOCKS; g++) begin : g_blk
      assign hit[g] = !boot_sel && (addr == USER_BLOCK_TOP[g]);
    end
  endgenerate

  // Area membership and block index
  always_comb begin
    in_user      = !boot_sel && (addr >= USER_BASE);
    in_boot      = boot_sel && (addr >= BOOT_BASE);
    user_top_hit = |hit;
    boot_top_hit = boot_sel && (addr == BOOT_TOP);
    blk_idx      = '0;
    for (int i = 0; i < USER_BLOCKS; i++) begin
      if (hit[i]) begin
        blk_idx = BLK_W'(i);
      end
    end
  end

endmodule

// File: flash_mode_boot_select.sv
module flash_mode_boot_select
  import fmbs_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire logic              boot_mode_select_pin,
  input  wire logic              chip_select_port_pin,
  input  wire logic              serial_clock_port_pin,
  input  wire fmbs_src_t         cmd_src,
  input  wire logic              cpu_rewrite_sel,
  input  wire logic              boot_area_sel,
  input  wire logic              read_protect_en,
  input  wire logic              boot_factory_content,
  input  wire logic              cmd_wr,
  input  wire logic              cmd_rd,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [DATA_W-1:0] cmd_wdata,
  output logic [DATA_W-1:0]      cmd_rdata,
  output logic                   cmd_rvalid,
  output logic                   start_user,
  output logic                   start_boot,
  output logic                   start_programmer,
  output logic                   start_valid,
  output logic                   cpu_fetch_ok,
  output logic                   serial_mode_ok,
  output logic                   ready_busy_flag,
  output logic [DATA_W-1:0]      status_out,
  output logic                   arr_req,
  output fmbs_op_t               arr_op,
  output logic [ADDR_W-1:0]      arr_addr,
  output logic [DATA_W-1:0]      arr_wdata,
  output logic                   arr_boot,
  output logic [BLK_W-1:0]       arr_blk,
  output logic                   arr_rd,
  input  wire logic [DATA_W-1:0] arr_rdata,
  input  wire logic              arr_done,
  input  wire logic              arr_fail
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PROG_ARG,
    ST_ERASE_ARG,
    ST_BUSY
  } fmbs_state_t;

  fmbs_state_t       state_reg, state_next;
  fmbs_start_t       start_reg, start_next;
  logic              strap_done_reg, strap_done_next;
  logic              rd_status_reg, rd_status_next;
  logic [DATA_W-1:0] status_reg, status_next;
  logic              req_reg, req_next;
  fmbs_op_t          op_reg, op_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [DATA_W-1:0] wdata_reg, wdata_next;
  logic              boot_reg, boot_next;
  logic [BLK_W-1:0]  blk_reg, blk_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic              rvalid_reg, rvalid_next;
  logic              pend_rd_reg, pend_rd_next;
  logic              pend_arr_reg, pend_arr_next;

  logic              in_user, in_boot, user_top_hit, boot_top_hit;
  logic [BLK_W-1:0]  blk_idx;
  logic              port_open, may_alter_boot, rd_locked;
  logic              wr_ok, rd_ok, target_ok, erase_ok;

  // Area and block decode of the command address
  fmbs_area_decode u_decode (
    .addr         (cmd_addr),
    .boot_sel     (boot_area_sel),
    .in_user      (in_user),
    .in_boot      (in_boot),
    .user_top_hit (user_top_hit),
    .boot_top_hit (boot_top_hit),
    .blk_idx      (blk_idx)
  );

  // Access permissions per source
  always_comb begin
    // Serial port shut once boot content is replaced
    port_open = strap_done_reg &&
                !(cmd_src == SRC_SERIAL && !boot_factory_content);
    // Boot area alteration reserved for parallel mode
    may_alter_boot = (cmd_src == SRC_PARALLEL);
    // Read-out protection for external programmers
    rd_locked = read_protect_en && (cmd_src != SRC_CPU);
    wr_ok     = cmd_wr && port_open;
    rd_ok     = cmd_rd && port_open;
    // Boot targets need parallel mode; CPU gets user area only
    target_ok = in_user || (in_boot && may_alter_boot);
    erase_ok  = user_top_hit || (boot_top_hit && may_alter_boot);
  end

  // Start area decode, taken once after reset release
  always_comb begin
    start_next      = start_reg;
    strap_done_next = 1'b1;
    if (!strap_done_reg) begin
      if (!boot_mode_select_pin) begin
        start_next = START_USER;
      end else if (chip_select_port_pin && serial_clock_port_pin) begin
        start_next = START_BOOT;
      end else begin
        start_next = START_PROGRAMMER;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      start_reg      <= START_USER;
      strap_done_reg <= 1'b0;
    end else begin
      start_reg      <= start_next;
      strap_done_reg <= strap_done_next;
    end
  end

  // Command sequencer, status and array requests
  always_comb begin
    state_next     = state_reg;
    rd_status_next = rd_status_reg;
    status_next    = status_reg;
    req_next       = 1'b0;
    op_next        = op_reg;
    addr_next      = addr_reg;
    wdata_next     = wdata_reg;
    boot_next      = boot_reg;
    blk_next       = blk_reg;
    case (state_reg)
      ST_IDLE: begin
        if (wr_ok) begin
          case (cmd_wdata)
            CMD_READ_ARRAY: begin
              rd_status_next = 1'b0;
            end
            CMD_READ_STATUS: begin
              rd_status_next = 1'b1;
            end
            CMD_CLEAR_STATUS: begin
              status_next[SR_ERASE_ERR_BIT] = 1'b0;
              status_next[SR_PROG_ERR_BIT]  = 1'b0;
            end
            CMD_PROGRAM: begin
              state_next = ST_PROG_ARG;
            end
            CMD_ERASE: begin
              state_next = ST_ERASE_ARG;
            end
            default: begin
              state_next = ST_IDLE;
            end
          endcase
        end
      end
      ST_PROG_ARG: begin
        if (wr_ok) begin
          rd_status_next = 1'b1;
          if (target_ok) begin
            // Second cycle carries address and byte
            req_next   = 1'b1;
            op_next    = OP_PROGRAM;
            addr_next  = cmd_addr;
            wdata_next = cmd_wdata;
            boot_next  = in_boot;
            state_next = ST_BUSY;
            status_next[SR_READY_BIT] = 1'b0;
          end else begin
            // Refused target leaves array untouched
            status_next[SR_PROG_ERR_BIT] = 1'b1;
            state_next = ST_IDLE;
          end
        end
      end
      ST_ERASE_ARG: begin
        if (wr_ok) begin
          rd_status_next = 1'b1;
          state_next     = ST_IDLE;
          if (cmd_wdata == CMD_ERASE) begin
            // Whole-array erase; boot block only from parallel mode
            req_next   = 1'b1;
            op_next    = OP_ERASE_ALL;
            addr_next  = cmd_addr;
            boot_next  = boot_area_sel && may_alter_boot;
            state_next = ST_BUSY;
            status_next[SR_READY_BIT] = 1'b0;
          end else if (cmd_wdata == CMD_ERASE_CONFIRM && erase_ok) begin
            req_next   = 1'b1;
            op_next    = OP_ERASE_BLOCK;
            addr_next  = cmd_addr;
            boot_next  = boot_top_hit;
            blk_next   = blk_idx;
            state_next = ST_BUSY;
            status_next[SR_READY_BIT] = 1'b0;
          end else begin
            status_next[SR_ERASE_ERR_BIT] = 1'b1;
          end
        end
      end
      ST_BUSY: begin
        // Writes ignored until the array finishes
        if (arr_done) begin
          status_next[SR_READY_BIT] = 1'b1;
          if (arr_fail) begin
            if (op_reg == OP_PROGRAM) begin
              status_next[SR_PROG_ERR_BIT] = 1'b1;
            end else begin
              status_next[SR_ERASE_ERR_BIT] = 1'b1;
            end
          end
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_reg     <= ST_IDLE;
      rd_status_reg <= 1'b0;
      status_reg    <= STATUS_RESET;
      req_reg       <= 1'b0;
      op_reg        <= OP_PROGRAM;
      addr_reg      <= '0;
      wdata_reg     <= DATA_ZERO;
      boot_reg      <= 1'b0;
      blk_reg       <= '0;
    end else begin
      state_reg     <= state_next;
      rd_status_reg <= rd_status_next;
      status_reg    <= status_next;
      req_reg       <= req_next;
      op_reg        <= op_next;
      addr_reg      <= addr_next;
      wdata_reg     <= wdata_next;
      boot_reg      <= boot_next;
      blk_reg       <= blk_next;
    end
  end

  // Read path: status, array byte or zero, answered two cycles after request
  always_comb begin
    pend_rd_next  = rd_ok;
    pend_arr_next = rd_ok && !rd_status_reg && !rd_locked &&
                    (state_reg != ST_BUSY);
    rvalid_next   = pend_rd_reg;
    rdata_next    = rdata_reg;
    if (pend_rd_reg) begin
      if (pend_arr_reg) begin
        rdata_next = arr_rdata;
      end else if (rd_status_reg || state_reg == ST_BUSY) begin
        rdata_next = status_reg;
      end else begin
        rdata_next = DATA_ZERO;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pend_rd_reg  <= 1'b0;
      pend_arr_reg <= 1'b0;
      rvalid_reg   <= 1'b0;
      rdata_reg    <= DATA_ZERO;
    end else begin
      pend_rd_reg  <= pend_rd_next;
      pend_arr_reg <= pend_arr_next;
      rvalid_reg   <= rvalid_next;
      rdata_reg    <= rdata_next;
    end
  end

  // Outputs
  assign cmd_rdata        = rdata_reg;
  assign cmd_rvalid       = rvalid_reg;
  assign start_user       = strap_done_reg && (start_reg == START_USER);
  assign start_boot       = strap_done_reg && (start_reg == START_BOOT);
  assign start_programmer = strap_done_reg &&
                            (start_reg == START_PROGRAMMER);
  assign start_valid      = strap_done_reg;
  // No instruction fetch from the array while rewriting
  assign cpu_fetch_ok     = !cpu_rewrite_sel;
  assign serial_mode_ok   = boot_factory_content;
  assign ready_busy_flag  = status_reg[SR_READY_BIT];
  assign status_out       = status_reg;
  assign arr_req          = req_reg;
  assign arr_op           = op_reg;
  assign arr_addr         = addr_reg;
  assign arr_wdata        = wdata_reg;
  assign arr_boot         = boot_reg;
  assign arr_blk          = blk_reg;
  assign arr_rd           = pend_arr_reg;

endmodule

// File: fmbs_array_model.sv
module fmbs_array_model
  import fmbs_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire logic              arr_req,
  input  wire logic              arr_rd,
  input  wire logic [ADDR_W-1:0] arr_addr,
  input  wire logic [3:0]        lat,
  input  wire logic              fail_on,
  output logic [DATA_W-1:0]      arr_rdata,
  output logic                   arr_done,
  output logic                   arr_fail
);
  logic [3:0] cnt_reg;
  logic       run_reg;
  logic       junk_reg;

  // Read data only in the read cycle, a toggling pattern otherwise
  assign arr_rdata = arr_rd ? 8'hA5 : {8{junk_reg}};
  assign arr_fail  = fail_on; // Failure flag follows fail_on in every cycle, not only with a done pulse

  // Finish each operation lat cycles after its request
  always_ff @(posedge core_clk) begin
    junk_reg <= ~junk_reg;
    arr_done <= 1'b0;
    if (!rst_b) begin
      junk_reg <= 1'b0;
      run_reg <= 1'b0;
      cnt_reg <= 4'h0;
    end else if (arr_req) begin
      run_reg <= 1'b1;
      cnt_reg <= lat;
    end else if (run_reg && cnt_reg <= 4'h1) begin
      run_reg  <= 1'b0;
      arr_done <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg - 4'h1;
    end
  end
endmodule

// File: fmbs_checker.sv
module fmbs_checker
  import fmbs_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              rst_b,
  input wire logic              boot_mode_select_pin,
  input wire logic              chip_select_port_pin,
  input wire logic              serial_clock_port_pin,
  input wire fmbs_src_t         cmd_src,
  input wire logic              cpu_rewrite_sel,
  input wire logic              boot_factory_content,
  input wire logic              cmd_wr,
  input wire logic              cmd_rd,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [DATA_W-1:0] cmd_wdata,
  input wire logic              cmd_rvalid,
  input wire logic              start_user,
  input wire logic              start_boot,
  input wire logic              start_programmer,
  input wire logic              start_valid,
  input wire logic              cpu_fetch_ok,
  input wire logic              serial_mode_ok,
  input wire logic              ready_busy_flag,
  input wire logic [DATA_W-1:0] status_out,
  input wire logic              arr_req,
  input wire fmbs_op_t          arr_op,
  input wire logic [ADDR_W-1:0] arr_addr,
  input wire logic [DATA_W-1:0] arr_wdata,
  input wire logic              arr_boot,
  input wire logic [BLK_W-1:0]  arr_blk,
  input wire logic              arr_done
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // Strap sampling at the first edge after reset release
  sequence s_rel_user;
    !start_valid && !boot_mode_select_pin ##1 start_valid;
  endsequence
  sequence s_rel_boot;
    !start_valid && boot_mode_select_pin && chip_select_port_pin
      && serial_clock_port_pin ##1 start_valid;
  endsequence

  a_user_start: assert property (s_rel_user |-> start_user)
    else $error("user start missing");
  a_boot_start: assert property (s_rel_boot |-> start_boot)
    else $error("boot start missing");
  a_start_onehot: assert property (
    start_valid |-> $onehot({start_user, start_boot, start_programmer}))
    else $error("start outputs not one-hot");
  a_fetch_block: assert property (cpu_rewrite_sel |-> !cpu_fetch_ok)
    else $error("fetch allowed while rewriting");
  a_serial_lock: assert property (
    serial_mode_ok == boot_factory_content)
    else $error("serial mode availability wrong");
  a_boot_parallel: assert property (
    arr_req && arr_boot |-> $past(cmd_src) == SRC_PARALLEL)
    else $error("boot area altered by non-parallel source");
  a_prog_pair: assert property (
    arr_req && arr_op == OP_PROGRAM |-> $past(cmd_wr) &&
    arr_addr == $past(cmd_addr) && arr_wdata == $past(cmd_wdata))
    else $error("program request not from second write");
  a_block_top: assert property (
    arr_req && arr_op == OP_ERASE_BLOCK && !arr_boot |->
    arr_addr[12:0] == 13'h1FFF && arr_blk == arr_addr[14:13])
    else $error("block erase not at block top");
  a_boot_block: assert property (
    arr_req && arr_boot && arr_op == OP_ERASE_BLOCK |-> arr_addr == BOOT_TOP)
    else $error("boot erase not at boot top");
  a_busy_req: assert property (arr_req |-> !ready_busy_flag [*2])
    else $error("ready while operation runs");
  a_ready_bit: assert property (
    ready_busy_flag == status_out[SR_READY_BIT])
    else $error("ready flag and status bit differ");
  a_ready_rise: assert property (
    $rose(ready_busy_flag) |-> $past(arr_done))
    else $error("ready rose without array done");
  a_read_lat: assert property (cmd_rvalid |-> $past(cmd_rd, 2))
    else $error("read answer at wrong time");
endmodule

bind flash_mode_boot_select fmbs_checker fmbs_checker_i (.*);

// File: flash_mode_boot_select_tb.sv
module flash_mode_boot_select_tb;
  import fmbs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic              core_clk = 1'b0;
  logic              rst_b, boot_mode_select_pin, chip_select_port_pin;
  logic              serial_clock_port_pin, cpu_rewrite_sel, boot_area_sel;
  logic              read_protect_en, boot_factory_content, cmd_wr, cmd_rd;
  logic              cmd_rvalid, start_user, start_boot, start_programmer;
  logic              start_valid, cpu_fetch_ok, serial_mode_ok;
  logic              arr_req, arr_boot, arr_rd, arr_done, arr_fail, cap_boot;
  logic              cap_busy, ready_busy_flag;
  logic              fail_on = 1'b0;
  fmbs_src_t         cmd_src;
  fmbs_op_t          arr_op, cap_op;
  logic [ADDR_W-1:0] cmd_addr, arr_addr, cap_addr, a;
  logic [DATA_W-1:0] cmd_wdata, cmd_rdata, status_out, arr_wdata, arr_rdata;
  logic [DATA_W-1:0] cap_data, d;
  logic [BLK_W-1:0]  arr_blk, cap_blk;
  logic [3:0]        lat = 4'h1;
  int                fail_count = 0, n_tests = 0, req_cnt = 0, n0, i;
  int                seed = 32'h11FF;

  flash_mode_boot_select flash_mode_boot_select_i (.*);
  fmbs_array_model fmbs_array_model_i (.*);

  always #5 core_clk = ~core_clk;

  // Capture each array request
  always @(posedge core_clk) begin
    if (arr_req) begin
      req_cnt  = req_cnt + 1;
      cap_addr = arr_addr;
      cap_data = arr_wdata;
      cap_op   = arr_op;
      cap_blk  = arr_blk;
      cap_boot = arr_boot;
      cap_busy = ready_busy_flag;
    end
  end

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic do_reset(input logic [2:0] p);
    @(posedge core_clk);
    rst_b <= 1'b0;
    {boot_mode_select_pin, chip_select_port_pin, serial_clock_port_pin} <= p;
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [15:0] ad, input logic [7:0] dt);
    @(posedge core_clk);
    cmd_wr    <= 1'b1;
    cmd_addr  <= ad;
    cmd_wdata <= dt;
    @(posedge core_clk);
    cmd_wr <= 1'b0;
  endtask

  task automatic wait_ready;
    for (int k = 0; k < 40 && ready_busy_flag !== 1'b1; k++) begin
      @(posedge core_clk);
      #1;
    end
    chk("ready_busy_flag", 1, ready_busy_flag);
    if (ready_busy_flag !== 1'b1) wrap_up;
  endtask

  // Two-write command, then count the array requests that follow
  task automatic cmd2(input logic [7:0] c, input logic [15:0] ad,
                      input logic [7:0] dt, input int e);
    n0 = req_cnt;
    wr(16'h8000, c);
    wr(ad, dt);
    repeat (3) @(posedge core_clk);
    #1;
    chk("arr_req count", 16'(e), 16'(req_cnt - n0));
    wait_ready();
  endtask

  task automatic rd(output logic [7:0] v);
    @(posedge core_clk);
    cmd_rd <= 1'b1;
    @(posedge core_clk);
    cmd_rd <= 1'b0;
    #1;
    // Answer is looked at while the valid pulse stands
    for (int k = 0; k < 4 && cmd_rvalid !== 1'b1; k++) begin
      @(posedge core_clk);
      #1;
    end
    chk("cmd_rvalid", 1, cmd_rvalid);
    if (cmd_rvalid !== 1'b1) wrap_up;
    v = cmd_rdata;
  endtask

  // Main sequence
  initial begin
    {rst_b, cmd_wr, cmd_rd, cpu_rewrite_sel} = '0;
    {boot_area_sel, read_protect_en} = '0;
    {cmd_addr, cmd_wdata, boot_mode_select_pin} = '0;
    {chip_select_port_pin, serial_clock_port_pin} = '0;
    cmd_src = SRC_CPU;
    boot_factory_content = 1'b1;
    do_reset(3'b000);
    chk("start_user", 1, start_user);
    do_reset(3'b111);
    chk("start_boot", 1, start_boot);
    do_reset(3'b100);
    chk("start_programmer", 1, start_programmer);
    chk("cpu_fetch_ok", 1, cpu_fetch_ok);
    @(posedge core_clk);
    cpu_rewrite_sel <= 1'b1;
    #1 chk("cpu_fetch_ok", 0, cpu_fetch_ok);
    // Byte programs in the user area, corners first
    for (i = 0; i < 20; i++) begin
      a = i == 0 ? 16'h8000 : i == 1 ? 16'hFFFF :
          16'h8000 | 16'($random(seed));
      d = 8'($random(seed));
      lat = 4'($random(seed)) | 4'h1;
      cmd2(CMD_PROGRAM, a, d, 1);
      chk("arr_addr", a, cap_addr);
      chk("arr_wdata", 16'(d), 16'(cap_data));
      chk("arr_op", 16'(OP_PROGRAM), 16'(cap_op));
      chk("busy at start", 0, cap_busy);
    end
    // Boot area program from each source
    for (i = 0; i < 3; i++) begin
      @(posedge core_clk);
      cmd_src <= fmbs_src_t'(i);
      boot_area_sel <= 1'b1;
      wr(16'h8000, CMD_CLEAR_STATUS);
      cmd2(CMD_PROGRAM, 16'hF123, 8'h3C, i == 1);
      chk("prog error", 16'(i != 1), status_out[SR_PROG_ERR_BIT]);
    end
    chk("arr_boot", 1, cap_boot);
    // Serial source may not erase the boot block, parallel may
    cmd2(CMD_ERASE, BOOT_TOP, CMD_ERASE_CONFIRM, 0);
    chk("boot erase error", 1, status_out[SR_ERASE_ERR_BIT]);
    @(posedge core_clk);
    cmd_src <= SRC_PARALLEL;
    cmd2(CMD_ERASE, BOOT_TOP, CMD_ERASE_CONFIRM, 1);
    chk("boot erase", 1, cap_boot);
    cmd2(CMD_ERASE, BOOT_BASE, CMD_ERASE_CONFIRM, 0);
    @(posedge core_clk);
    cmd_src <= SRC_CPU;
    boot_area_sel <= 1'b0;
    // Block erase at every block top
    for (i = 0; i < USER_BLOCKS; i++) begin
      cmd2(CMD_ERASE, USER_BLOCK_TOP[i], CMD_ERASE_CONFIRM, 1);
      chk("arr_blk", 16'(i), 16'(cap_blk));
    end
    // Array reports failure: error bit follows the operation kind
    wr(16'h8000, CMD_CLEAR_STATUS);
    fail_on <= 1'b1;
    cmd2(CMD_PROGRAM, 16'h8800, 8'h5A, 1);
    chk("fail prog error", 1, status_out[SR_PROG_ERR_BIT]);
    chk("fail erase error", 0, status_out[SR_ERASE_ERR_BIT]);
    cmd2(CMD_ERASE, 16'hBFFF, CMD_ERASE_CONFIRM, 1);
    chk("fail erase error", 1, status_out[SR_ERASE_ERR_BIT]);
    fail_on <= 1'b0;
    wr(16'h8000, CMD_CLEAR_STATUS);
    cmd2(CMD_ERASE, 16'h9FFE, CMD_ERASE_CONFIRM, 0);
    chk("erase error", 1, status_out[SR_ERASE_ERR_BIT]);
    cmd2(CMD_ERASE, 16'h8000, CMD_ERASE, 1);
    chk("erase all", 16'(OP_ERASE_ALL), 16'(cap_op));
    // Status read, protected read, serial lock-out
    wr(16'h8000, CMD_CLEAR_STATUS);
    wr(16'h8000, CMD_READ_STATUS);
    rd(d);
    chk("status read", 16'(STATUS_RESET), 16'(d));
    wr(16'h8000, CMD_READ_ARRAY);
    rd(d);
    chk("array read", 16'h00A5, 16'(d));
    @(posedge core_clk);
    cmd_src <= SRC_PARALLEL;
    read_protect_en <= 1'b1;
    wr(16'h8000, CMD_READ_ARRAY);
    rd(d);
    chk("protected read", 0, 16'(d));
    @(posedge core_clk);
    cmd_src <= SRC_SERIAL;
    boot_factory_content <= 1'b0;
    #1 chk("serial_mode_ok", 0, serial_mode_ok);
    cmd2(CMD_PROGRAM, 16'h8100, 8'h11, 0);
    wrap_up;
  end
endmodule
